/* File: hw/lfps_map.svh */
`ifndef LFPS_MAP_SVH
`define LFPS_MAP_SVH
// ====================
// register offsets
`define LFPS_CTRL_OFS    8'h00
`define LFPS_ONTIME_OFS  8'h04
`define LFPS_CURR_OFS    8'h08
`define LFPS_OFFSET_OFS  8'h0C
`define LFPS_COUNT_OFS   8'h10
`define LFPS_STATUS_OFS  8'h14
`define LFPS_MASK_OFS    8'h18
`define LFPS_STATE_OFS   8'h1C
`define LFPS_DELAY_OFS   8'h20
`define LFPS_FRAME_OFS   8'h24
// ====================
// control fields
`define LFPS_C_RUN   0
`define LFPS_C_EXT   1
`define LFPS_C_BRK   2
`define LFPS_C_STEP  6:4
`define LFPS_C_SWBN  8
`define LFPS_C_SWSH  9
// status fields
`define LFPS_S_END   0
`define LFPS_S_EXT   1
`define LFPS_S_TMO   2
`define LFPS_S_ABT   3
`define LFPS_S_IGN   4
// ====================
// reset values
`define LFPS_CTRL_RST   32'h0000_0100
`define LFPS_ONTIME_RST 32'h0000_00FA
`define LFPS_CURR_RST   32'h0000_00C8
`define LFPS_FRAME_RST  32'h0000_03E8
// ====================
// timing
`define LFPS_CLK_MHZ        250
`define LFPS_CLK_NS         4
`define LFPS_TRIG_DELAY_US  10
`define LFPS_TICK_US        100
`define LFPS_TIMEOUT_S      5
`define LFPS_START_MAX_US   2
`define LFPS_PRE_LO_NS      1000
`define LFPS_PRE_MID_NS     2000
`define LFPS_PRE_HI_NS      3000
`define LFPS_PRE_MAX_NS     4000
`define LFPS_I_LO_MA        600
`define LFPS_I_MID_MA       1200
`define LFPS_I_HI_MA        1800
`endif

/* File: hw/lfps_pkg.sv */
package lfps_pkg;
  typedef enum logic [1:0] {
    LFPS_IDLE  = 2'b00,
    LFPS_CHECK = 2'b01,
    LFPS_RUN   = 2'b11
  } lfps_state_e;
  typedef logic [31:0] lfps_word_t;
endpackage : lfps_pkg

/* File: hw/lfps_top.sv */
`timescale 1ns/1ps
`include "lfps_map.svh"
// Functional notes
// - on trigger, turn on short switch, then buck at its match, so inductor current builds
// - release short switch after precharge chosen from LED current
// - compare timer edges placed on a 4 ns grid
// - active-low buck enable: low on its match, high at sequence end
// - short switch high at start, cleared by its match after precharge
// - sequence end: buck off, interrupt, timer stop, outputs back to software
// - buck start delayed to keep trigger-to-flash constant, plus adjustable offset
// - trigger-to-flash default 10 us, never shorter than the precharge
// - external mode: no periodic tick; 5 s without edge fires one housekeeping tick
// - internal mode: 100 us tick paces flashes and housekeeping
// - sequence starts (short switch on) under 2 us after an external trigger
// - after start check temperature, run flag, pulse count; abort before light
// - sample active-low overtemperature alert before each flash, suppress when set
// - bracketing row from step select 1 to 5, column from pulse number
// - five factors per row, unity third; smallest row 0.707 to 1.414
module lfps_top #(
  parameter int TICK_CYC    = `LFPS_TICK_US * `LFPS_CLK_MHZ,
  parameter int TIMEOUT_CYC = `LFPS_TIMEOUT_S * 1000000 * `LFPS_CLK_MHZ
) (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire lfps_pkg::lfps_word_t pwdata,
  output logic                    pready,
  output lfps_pkg::lfps_word_t    prdata,
  output logic                    pslverr,
  input  wire logic               trigInN,
  input  wire logic               overTempN,
  output logic                    buckEnN,
  output logic                    shortOn,
  output logic                    tickOut,
  output logic                    irq
);
  import lfps_pkg::*;

  localparam int DELAY_CYC = `LFPS_TRIG_DELAY_US * `LFPS_CLK_MHZ;

  // ====================
  // helpers
  function automatic logic [31:0] prechargeCyc(input logic [31:0] ma);
    if (ma <= `LFPS_I_LO_MA)
      prechargeCyc = 32'(`LFPS_PRE_LO_NS / `LFPS_CLK_NS);
    else if (ma <= `LFPS_I_MID_MA)
      prechargeCyc = 32'(`LFPS_PRE_MID_NS / `LFPS_CLK_NS);
    else if (ma <= `LFPS_I_HI_MA)
      prechargeCyc = 32'(`LFPS_PRE_HI_NS / `LFPS_CLK_NS);
    else
      prechargeCyc = 32'(`LFPS_PRE_MAX_NS / `LFPS_CLK_NS);
  endfunction : prechargeCyc

  // factors in 1/256 units; row 0 holds the finest step
  function automatic logic [12:0] brkFactor(input logic [2:0] row, input logic [2:0] col);
    logic [12:0] f [0:4][0:4];
    f = '{'{13'h0B5, 13'h0D7, 13'h100, 13'h130, 13'h16A},
          '{13'h0A1, 13'h0CB, 13'h100, 13'h143, 13'h196},
          '{13'h080, 13'h0B5, 13'h100, 13'h16A, 13'h200},
          '{13'h040, 13'h080, 13'h100, 13'h200, 13'h400},
          '{13'h010, 13'h040, 13'h100, 13'h400, 13'h1000}};
    if (row >= 3'h1 && row <= 3'h5 && col <= 3'h4)
      brkFactor = f[row - 3'h1][col];
    else
      brkFactor = 13'h100;
  endfunction : brkFactor

  // write strobe for one offset; shared by the clear paths
  function automatic logic wrHit(input logic we, input logic [7:0] a, input logic [7:0] ofs);
    wrHit = we && (a == ofs);
  endfunction : wrHit

  // ====================
  // registers
  lfps_word_t  ctrl_reg, onTime_reg, curr_reg, offset_reg, count_reg;
  lfps_word_t  delay_reg, frame_reg;
  logic [4:0]  status_reg, mask_reg;
  logic [4:0]  evt;
  lfps_state_e state_reg, state_next;
  logic [31:0] timer_reg, buckCmp_reg, shortCmp_reg, endCmp_reg;
  logic [31:0] done_reg, tickCnt_reg, frameCnt_reg, tmoCnt_reg;
  logic [2:0]  col_reg;
  logic [1:0]  trigSync_reg, otSync_reg;
  logic        trigLast_reg;
  logic        wrEn, rdEn, mapped;
  logic        extEdge, tick, intTrig, trigger, abort, seqEnd, countReached;
  logic [31:0] prech, flashAt, scaled;
  logic [44:0] product;

  assign wrEn = psel & penable & pwrite & pready;
  assign rdEn = psel & ~penable & ~pwrite;
  assign mapped = (paddr <= `LFPS_FRAME_OFS) && (paddr[1:0] == 2'b00);

  // ====================
  // apb: no wait state, answer in the first access cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn) begin
      case (paddr)
        `LFPS_CTRL_OFS:   prdata <= ctrl_reg;
        `LFPS_ONTIME_OFS: prdata <= onTime_reg;
        `LFPS_CURR_OFS:   prdata <= curr_reg;
        `LFPS_OFFSET_OFS: prdata <= offset_reg;
        `LFPS_COUNT_OFS:  prdata <= count_reg;
        `LFPS_STATUS_OFS: prdata <= {27'h0, status_reg};
        `LFPS_MASK_OFS:   prdata <= {27'h0, mask_reg};
        `LFPS_STATE_OFS:  prdata <= {otSync_reg[1], 1'b0, state_reg, 1'b0, col_reg,
                                     24'(done_reg)};
        `LFPS_DELAY_OFS:  prdata <= delay_reg;
        `LFPS_FRAME_OFS:  prdata <= frame_reg;
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_reg   <= `LFPS_CTRL_RST;
      onTime_reg <= `LFPS_ONTIME_RST;
      curr_reg   <= `LFPS_CURR_RST;
      offset_reg <= 32'h0000_0000;
      count_reg  <= 32'h0000_0000;
      mask_reg   <= 5'h00;
      delay_reg  <= 32'(DELAY_CYC);
      frame_reg  <= `LFPS_FRAME_RST;
    end else if (wrEn) begin
      case (paddr)
        `LFPS_CTRL_OFS:   ctrl_reg   <= pwdata;
        `LFPS_ONTIME_OFS: onTime_reg <= pwdata;
        `LFPS_CURR_OFS:   curr_reg   <= pwdata;
        `LFPS_OFFSET_OFS: offset_reg <= pwdata;
        `LFPS_COUNT_OFS:  count_reg  <= pwdata;
        `LFPS_MASK_OFS:   mask_reg   <= pwdata[4:0];
        `LFPS_DELAY_OFS:  delay_reg  <= pwdata;
        `LFPS_FRAME_OFS:  frame_reg  <= pwdata;
        default:          ctrl_reg   <= ctrl_reg;
      endcase
    end
  end

  // ====================
  // pin synchronisers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      trigSync_reg <= 2'b11;
      otSync_reg   <= 2'b11;
      trigLast_reg <= 1'b1;
    end else begin
      trigSync_reg <= {trigSync_reg[0], trigInN};
      otSync_reg   <= {otSync_reg[0], overTempN};
      trigLast_reg <= trigSync_reg[1];
    end
  end

  assign extEdge = ctrl_reg[`LFPS_C_EXT] & trigLast_reg & ~trigSync_reg[1];

  // ====================
  // pacing tick and external timeout
  always_ff @(posedge sys_clk) begin
    if (sys_rst || ctrl_reg[`LFPS_C_EXT]) begin
      tickCnt_reg <= 32'h0000_0000;
    end else if (tickCnt_reg == 32'(TICK_CYC - 1)) begin
      tickCnt_reg <= 32'h0000_0000;
    end else begin
      tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
    end
  end
  assign tick = ~ctrl_reg[`LFPS_C_EXT] && (tickCnt_reg == 32'(TICK_CYC - 1));

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !ctrl_reg[`LFPS_C_EXT] || extEdge) begin
      tmoCnt_reg <= 32'h0000_0000;
    end else if (tmoCnt_reg == 32'(TIMEOUT_CYC - 1)) begin
      tmoCnt_reg <= 32'h0000_0000;
    end else begin
      tmoCnt_reg <= tmoCnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tickOut <= 1'b0;
    end else begin
      tickOut <= tick | (evt[`LFPS_S_TMO]);
    end
  end

  // frame divider: flash every frame_reg ticks
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      frameCnt_reg <= 32'h0000_0000;
    end else if (tick) begin
      frameCnt_reg <= (frameCnt_reg + 32'h0000_0001 >= frame_reg) ? 32'h0000_0000
                                                                 : frameCnt_reg + 32'h0000_0001;
    end
  end
  assign intTrig = tick && (frameCnt_reg + 32'h0000_0001 >= frame_reg)
                   && ctrl_reg[`LFPS_C_RUN];
  // pin edge to sequence start is three clocks, far inside the start limit
  assign trigger = extEdge | intTrig;

  // ====================
  // compare values, taken at trigger
  assign prech   = prechargeCyc(curr_reg);
  // never shorter than the precharge, else the inductor is not charged
  assign flashAt = (delay_reg + offset_reg > prech) ? delay_reg + offset_reg
                                                    : prech + 32'h0000_0001;
  assign product = onTime_reg * brkFactor(ctrl_reg[`LFPS_C_STEP], col_reg);
  assign scaled  = ctrl_reg[`LFPS_C_BRK] ? (product[44:40] != 5'h00 ? 32'hFFFF_0000
                                                                    : product[39:8])
                                         : onTime_reg;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      buckCmp_reg  <= 32'h0000_0000;
      shortCmp_reg <= 32'h0000_0000;
      endCmp_reg   <= 32'h0000_0000;
    end else if (state_reg == LFPS_IDLE && trigger) begin
      buckCmp_reg  <= flashAt - prech;
      shortCmp_reg <= flashAt;
      endCmp_reg   <= flashAt + scaled;
    end
  end

  // ====================
  // sequencer
  assign countReached = (count_reg != 32'h0000_0000) && (done_reg >= count_reg);
  assign abort = ~otSync_reg[1] | ~ctrl_reg[`LFPS_C_RUN] | countReached;
  // decided one count early: registered outputs then leave exactly on the end count,
  // so the light lasts the scheduled on-time and not one clock more
  assign seqEnd = (state_reg == LFPS_RUN) && (timer_reg + 32'h0000_0001 == endCmp_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LFPS_IDLE:  if (trigger) begin
        state_next = LFPS_CHECK;
      end
      LFPS_CHECK: state_next = abort ? LFPS_IDLE : LFPS_RUN;
      LFPS_RUN: begin
        if (seqEnd || (timer_reg < shortCmp_reg && abort))
          state_next = LFPS_IDLE;
      end
      default:    state_next = LFPS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= LFPS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // one count per 4 ns clock
  always_ff @(posedge sys_clk) begin
    if (sys_rst || state_next == LFPS_IDLE) begin
      timer_reg <= 32'h0000_0000;
    end else begin
      timer_reg <= timer_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || wrHit(wrEn, paddr, `LFPS_CTRL_OFS)) begin
      done_reg <= 32'h0000_0000;
      col_reg  <= 3'h0;
    end else if (seqEnd) begin
      done_reg <= done_reg + 32'h0000_0001;
      col_reg  <= (col_reg == 3'h4) ? 3'h0 : col_reg + 3'h1;
    end
  end

  // outputs: under timer control while busy, else software levels
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      buckEnN <= 1'b1;
      shortOn <= 1'b0;
    end else if (state_next == LFPS_IDLE) begin
      buckEnN <= ctrl_reg[`LFPS_C_SWBN];
      shortOn <= ctrl_reg[`LFPS_C_SWSH];
    end else if (state_reg == LFPS_IDLE) begin
      shortOn <= 1'b1;
      // compare registers load on this same edge, so decide from their next value
      buckEnN <= (flashAt - prech == 32'h0000_0001) ? 1'b0 : 1'b1;
    end else begin
      if (timer_reg + 32'h0000_0001 == buckCmp_reg)
        buckEnN <= 1'b0;
      if (timer_reg + 32'h0000_0001 == shortCmp_reg)
        shortOn <= 1'b0;
    end
  end

  // ====================
  // interrupt status
  always_comb begin
    evt = 5'h00;
    evt[`LFPS_S_END] = seqEnd;
    evt[`LFPS_S_EXT] = extEdge;
    evt[`LFPS_S_TMO] = ctrl_reg[`LFPS_C_EXT] && (tmoCnt_reg == 32'(TIMEOUT_CYC - 1));
    evt[`LFPS_S_ABT] = (state_reg != LFPS_IDLE) && (state_next == LFPS_IDLE) && !seqEnd;
    evt[`LFPS_S_IGN] = trigger && (state_reg != LFPS_IDLE);
  end

  // a set in the clearing cycle wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status_reg <= 5'h00;
    end else if (wrHit(wrEn, paddr, `LFPS_STATUS_OFS)) begin
      status_reg <= (status_reg & ~pwdata[4:0]) | evt;
    end else begin
      status_reg <= status_reg | evt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

endmodule : lfps_top

/* File: testbench/lfps_top_asserts.sv */
`timescale 1ns/1ps
// ===
// port checker
module lfps_top_asserts (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       overTempN,
  input wire logic       buckEnN,
  input wire logic       shortOn,
  input wire logic       tickOut
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ready_next_a: assert property (psel && !penable |=> pready)
    else $error("access not answered");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_unmapped_a: assert property (pready && paddr > 8'h24 |-> pslverr)
    else $error("unmapped access accepted");
  buck_in_short_a: assert property ($fell(buckEnN) |-> shortOn)
    else $error("buck started without short");
  short_hold_a: assert property ($fell(buckEnN) |-> shortOn [*8])
    else $error("short released too soon");
  tick_pulse_a: assert property (tickOut |=> !tickOut [*8])
    else $error("tick too frequent");
  hot_block_a: assert property (!overTempN [*8] |-> !$fell(buckEnN))
    else $error("flash while hot");
endmodule : lfps_top_asserts
bind lfps_top lfps_top_asserts chkI (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .overTempN(overTempN), .buckEnN(buckEnN), .shortOn(shortOn), .tickOut(tickOut));

/* File: testbench/lfps_partner.sv */
`timescale 1ns/1ps
// ===
// camera trigger and power stage
module lfps_partner (
  input  wire logic sys_clk,
  input  wire logic fire,
  input  wire logic buckEnN,
  input  wire logic shortOn,
  output logic      trigInN,
  output int        lowCyc,
  output int        ovlCyc,
  output int        fallCyc,
  output int        startCyc
);
  int   age = 0;
  logic shortQ = 1'b0;
  initial begin
    trigInN = 1'b1;
    lowCyc = 0;
    ovlCyc = 0;
    fallCyc = 0;
    startCyc = 0;
  end
  always @(posedge sys_clk) begin
    trigInN <= ~fire;
    shortQ <= shortOn;
    age <= age + 1;
    if (fire && trigInN) begin
      age <= 0;
      lowCyc <= 0;
      ovlCyc <= 0;
    end else begin
      if (!buckEnN) lowCyc <= lowCyc + 1;
      if (!buckEnN && shortOn) ovlCyc <= ovlCyc + 1;
      if (shortQ && !shortOn) fallCyc <= age;
      if (!shortQ && shortOn) startCyc <= age;
    end
  end
endmodule : lfps_partner

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`include "lfps_map.svh"
module testbench;
  import lfps_pkg::*;
  logic       sys_clk, sys_rst, psel, penable, pwrite, fire, overTempN, trigInN, qErr;
  logic       pready, pslverr, buckEnN, shortOn, tickOut, irq;
  logic [7:0] paddr;
  lfps_word_t pwdata, prdata, q;
  int         lowCyc, ovlCyc, fallCyc, startCyc, failCount = 0, cmpCount = 0, cyc = 0;
  lfps_top #(.TICK_CYC(50), .TIMEOUT_CYC(200)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .trigInN(trigInN),
    .overTempN(overTempN), .buckEnN(buckEnN), .shortOn(shortOn), .tickOut(tickOut),
    .irq(irq));
  lfps_partner farI (.sys_clk(sys_clk), .fire(fire), .buckEnN(buckEnN), .shortOn(shortOn),
    .trigInN(trigInN), .lowCyc(lowCyc), .ovlCyc(ovlCyc), .fallCyc(fallCyc),
    .startCyc(startCyc));
  // ===
  // shared tasks
  task automatic chk(input lfps_word_t got, input lfps_word_t exp);
    cmpCount++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input lfps_word_t d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    qErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input lfps_word_t d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic clr();
    wr(`LFPS_STATUS_OFS, 32'h1F);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
  endtask : clr
  task automatic trig();
    fire <= 1'b1;
    repeat (4) @(posedge sys_clk);
    fire <= 1'b0;
    @(posedge sys_clk);
  endtask : trig
  task automatic pulse(input int ovl, input int low);
    trig();
    while (irq !== 1'b1) @(posedge sys_clk);
    chk(ovlCyc, ovl);
    chk(lowCyc, low);
    chk({buckEnN, shortOn}, 2'b10);
    rd(`LFPS_STATUS_OFS);
    chk(q[0], 1'b1);
    clr();
  endtask : pulse
  task automatic refuse();
    trig();
    repeat (600) @(posedge sys_clk);
    rd(`LFPS_STATUS_OFS);
    chk(q[3], 1'b1);
    chk(lowCyc, 0);
    clr();
  endtask : refuse
  task automatic tickGap(output int g);
    while (tickOut !== 1'b1) @(posedge sys_clk);
    g = 0;
    do begin
      @(posedge sys_clk);
      g++;
    end while (tickOut !== 1'b1);
  endtask : tickGap
  // ===
  // scenarios
  task automatic tReset();
    logic [7:0] a [6] = '{`LFPS_CTRL_OFS, `LFPS_ONTIME_OFS, `LFPS_CURR_OFS,
                          `LFPS_FRAME_OFS, `LFPS_DELAY_OFS, 8'hFC};
    lfps_word_t e [6] = '{`LFPS_CTRL_RST, `LFPS_ONTIME_RST, `LFPS_CURR_RST,
                          `LFPS_FRAME_RST, 32'h9C4, 32'h0};
    chk({buckEnN, shortOn, irq}, 3'b100);
    foreach (a[i]) begin
      rd(a[i]);
      chk(q, e[i]);
      chk(qErr, i == 5);
    end
  endtask : tReset
  task automatic tExt();
    int f0;
    wr(`LFPS_MASK_OFS, 32'h1);
    wr(`LFPS_ONTIME_OFS, 32'h14);
    wr(`LFPS_CTRL_OFS, 32'h103);
    pulse(250, 270);
    chk(fallCyc >= 2500 && fallCyc <= 2510, 1'b1);
    chk(startCyc < 500, 1'b1);
    wr(`LFPS_DELAY_OFS, 32'h12C);
    pulse(250, 270);
    f0 = fallCyc;
    wr(`LFPS_OFFSET_OFS, 32'h64);
    pulse(250, 270);
    chk(fallCyc - f0, 32'h64);
    wr(`LFPS_OFFSET_OFS, 32'h0);
    wr(`LFPS_CURR_OFS, 32'h3E8);
    pulse(500, 520);
    chk(fallCyc - f0, 32'hC9);
    wr(`LFPS_CURR_OFS, 32'hC8);
    trig();
    repeat (50) @(posedge sys_clk);
    trig();
    while (irq !== 1'b1) @(posedge sys_clk);
    rd(`LFPS_STATUS_OFS);
    chk(q[4], 1'b1);
    clr();
  endtask : tExt
  task automatic tAbort();
    overTempN <= 1'b0;
    refuse();
    overTempN <= 1'b1;
    wr(`LFPS_CTRL_OFS, 32'h102);
    refuse();
    wr(`LFPS_COUNT_OFS, 32'h1);
    wr(`LFPS_CTRL_OFS, 32'h103);
    pulse(250, 270);
    refuse();
    wr(`LFPS_COUNT_OFS, 32'h0);
  endtask : tAbort
  task automatic tTicks();
    int g;
    tickGap(g);
    chk(g, 200);
    wr(`LFPS_FRAME_OFS, 32'h14);
    wr(`LFPS_CTRL_OFS, 32'h101);
    tickGap(g);
    chk(g, 50);
    while (irq !== 1'b1) @(posedge sys_clk);
    chk({buckEnN, shortOn}, 2'b10);
    clr();
  endtask : tTicks
  task automatic tBracket();
    int f [5] = '{181, 215, 256, 304, 362};
    wr(`LFPS_ONTIME_OFS, 32'h100);
    wr(`LFPS_CTRL_OFS, 32'h117);
    foreach (f[i]) pulse(250, 250 + f[i]);
  endtask : tBracket
  task automatic summarize();
    if (failCount == 0 && cmpCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // ===
  // clock, watchdog, sequence
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failCount++;
      summarize();
    end
  end
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, fire, paddr, pwdata} = '0;
    overTempN = 1'b1;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    tReset();
    tExt();
    tAbort();
    tTicks();
    tBracket();
    summarize();
  end
endmodule : testbench
